// File: logic/dpos_pkg.sv
// Shared constants and types for the divider phase offset select block
package dpos_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] DPOS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DPOS_DIV_OFS    = 8'h04;
  localparam logic [7:0] DPOS_STATUS_OFS = 8'h08;
  localparam logic [7:0] DPOS_DELAY_OFS  = 8'h0c;

  // Control register fields
  localparam int unsigned DPOS_CTRL_SYNC_BIT = 0;
  localparam int unsigned DPOS_CTRL_SE_BIT   = 1;
  localparam int unsigned DPOS_CTRL_OFF0_BIT = 2;
  localparam logic [2:0]  DPOS_CTRL_RST      = 3'h0;

  // Divider register fields: ratio minus one and table phase per output
  localparam int unsigned DPOS_DIV0_RATIO_LSB = 0;
  localparam int unsigned DPOS_DIV1_RATIO_LSB = 8;
  localparam int unsigned DPOS_DIV0_PHASE_LSB = 16;
  localparam int unsigned DPOS_DIV1_PHASE_LSB = 24;
  localparam logic [31:0] DPOS_DIV_RST        = 32'h0000_0303;

  // Status register fields
  localparam int unsigned DPOS_ST_WORD_LSB   = 0;
  localparam int unsigned DPOS_ST_TGT_LSB    = 4;
  localparam int unsigned DPOS_ST_PD_LSB     = 6;
  localparam int unsigned DPOS_ST_RUN_LSB    = 11;
  localparam int unsigned DPOS_ST_PHASE0_LSB = 16;
  localparam int unsigned DPOS_ST_PHASE1_LSB = 20;

  // Four-level pin codes: 0, 1/3, 2/3 and 1 of the supply
  localparam logic [1:0] DPOS_LVL_0   = 2'h0;
  localparam logic [1:0] DPOS_LVL_1_3 = 2'h1;
  localparam logic [1:0] DPOS_LVL_2_3 = 2'h2;
  localparam logic [1:0] DPOS_LVL_1   = 2'h3;

  // Delay full-scale values in picoseconds, fine steps per full scale
  localparam int unsigned DPOS_FS_A_PS     = 1500;
  localparam int unsigned DPOS_FS_B_PS     = 5000;
  localparam int unsigned DPOS_FS_C_PS     = 10000;
  localparam int unsigned DPOS_FINE_STEPS  = 16;
  localparam int unsigned DPOS_MAX_PHASE   = 15;

  // AXI responses
  localparam logic [1:0] DPOS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DPOS_RESP_SLVERR = 2'h2;

  // Divider sequencing states
  typedef enum logic [1:0] {
    DPOS_ST_IDLE = 2'b00,
    DPOS_ST_WAIT = 2'b01,
    DPOS_ST_RUN  = 2'b10
  } dpos_div_st_t;

endpackage : dpos_pkg

// File: logic/dpos_divider.sv
// Output divider with phase offset wait and start-high choice
`timescale 1ns/100ps
`default_nettype none
module dpos_divider #(
  parameter int unsigned RATIO_W = 6,
  parameter int unsigned PHASE_W = 4
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic [PHASE_W-1:0] phase,
  input  wire logic               start_high,
  input  wire logic               sync,
  input  wire logic               powerdown,
  output var  logic               div_out_q,
  output var  logic               running_q
);
  import dpos_pkg::*;

  // Ratio must reach 32 and phase must reach 15
  if (RATIO_W < 6 || PHASE_W < 4) begin : g_chk
    $error("dpos_divider: width parameters too small");
  end

  dpos_div_st_t       st_q;
  logic [PHASE_W-1:0] wait_q;
  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] cnt_d;
  logic [RATIO_W-1:0] hi_len;
  logic               sh_q;
  logic [RATIO_W-1:0] ratio_q;

  // Level after the first edge lasts half the period, rounded up for odd ratios
  assign hi_len = RATIO_W'((ratio_q + 1'b1) >> 1);
  assign cnt_d  = (cnt_q >= ratio_q - 1'b1) ? '0 : cnt_q + 1'b1;

  // Sequencer: ratio, phase and start level are taken only at sync; powerdown acts at once without it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= DPOS_ST_IDLE;
      wait_q    <= '0;
      cnt_q     <= '0;
      sh_q      <= 1'b0;
      ratio_q   <= RATIO_W'(1);
      div_out_q <= 1'b0;
      running_q <= 1'b0;
    end else if (powerdown) begin
      st_q      <= DPOS_ST_IDLE;
      div_out_q <= 1'b0;
      running_q <= 1'b0;
    end else if (sync) begin
      st_q      <= DPOS_ST_WAIT;
      wait_q    <= phase;
      sh_q      <= start_high;
      ratio_q   <= (ratio == '0) ? RATIO_W'(1) : ratio;
      div_out_q <= start_high;
      running_q <= 1'b0;
    end else begin
      unique case (st_q)
        DPOS_ST_IDLE: begin
          div_out_q <= div_out_q;
        end
        DPOS_ST_WAIT: begin
          if (wait_q == '0) begin
            // First edge; an offset equal to the ratio lands a period late
            st_q      <= DPOS_ST_RUN;
            cnt_q     <= (ratio_q == RATIO_W'(1)) ? '0 : RATIO_W'(1);
            div_out_q <= ~sh_q;
            running_q <= 1'b1;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        DPOS_ST_RUN: begin
          cnt_q     <= cnt_d;
          div_out_q <= (cnt_q < hi_len) ^ sh_q;
        end
        default: begin
          st_q <= DPOS_ST_IDLE;
        end
      endcase
    end
  end

  // Level held between sync and the first edge
  sequence s_sync_taken;
    sync && !powerdown;
  endsequence

  property p_first_level;
    @(posedge aclk) disable iff (!aresetn)
      s_sync_taken |=> (div_out_q == $past(start_high));
  endproperty
  first_level_a: assert property (p_first_level)
    else $error("divider did not start at the chosen level");

  // Offset 2: wait counts at three edges, the flag is seen one edge later
  phase_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_sync_taken and (phase == 4'h2)) ##1 (!sync && !powerdown) [*3]
      |=> $past(running_q, 1) == 1'b0 && running_q)
    else $error("first edge not after the phase offset wait");

  pd_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    powerdown |=> !running_q && !div_out_q)
    else $error("powered down divider still active");

endmodule : dpos_divider
`default_nettype wire

// File: logic/dpos_top.sv
// Phase offset and delay word selection with AXI4-Lite control
// Overview of operation
// - Target pin routes word: lvds_cmos_clock_output phase, pecl_clock_output, lvds_cmos_clock_output start high, pecl_clock_output start high.
// - Two word pins decode as base-4 digits, low pin least significant, 0 to 15.
// - With lvds_cmos_clock_output delay enabled, word N gives delay of N/16 full scale.
// - Nonzero phase from the divider setting overrides the pin word phase.
// - After sync each divider waits its phase count of input clocks before an edge.
// - Offset step is one input clock; distinct offsets below ratio, max 15.
// - Offset equal to the divide ratio aligns the same as offset zero.
// - Lvds_cmos_clock_output delay full scale selectable as 1.5 ns, 5 ns or 10 ns.
// - Delay full-scale pin at level 0 bypasses and powers down the delay block.
// - A divider set to divide by one is bypassed and powered down.
// - An output set off powers down that output and its divider.
// - Single-ended mode drives true clock on primary, inverted on complementary.
// - Lvds_cmos_clock_output divider pin code 0, 1/3... levels 0,1,0 turns lvds_cmos_clock_output off.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dpos_top #(
  parameter int unsigned RATIO_W = 6
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic [1:0]  phase_target_select_pin,
  input  wire logic [1:0]  phase_word_low_pin,
  input  wire logic [1:0]  phase_word_high_pin,
  input  wire logic [1:0]  delay_fullscale_pin,
  input  wire logic [1:0]  second_div_sel_a,
  input  wire logic [1:0]  second_div_sel_b,
  input  wire logic [1:0]  second_div_sel_c,
  output var  logic        pecl_clock_output,
  output var  logic        lvds_cmos_clock_output,
  output var  logic        complementary_clock_output,
  output var  logic [3:0]  delay_fine_word,
  output var  logic [1:0]  delay_fullscale_sel,
  output var  logic [13:0] delay_amount_ps,
  output var  logic        delay_powerdown,
  output var  logic        div0_powerdown,
  output var  logic        div1_powerdown,
  output var  logic        pecl_clock_output_powerdown,
  output var  logic        lvds_cmos_clock_output_powerdown
);
  import dpos_pkg::*;

  if (RATIO_W < 6) begin : g_chk
    $error("dpos_top: RATIO_W must hold a ratio of 32");
  end

  // Two four-level digits form one word
  function automatic logic [3:0] dpos_word(input logic [1:0] hi, input logic [1:0] lo);
    dpos_word = {hi, lo};
  endfunction : dpos_word

  // Byte-lane merge for register writes
  function automatic logic [31:0] dpos_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    dpos_merge = res;
  endfunction : dpos_merge

  logic [2:0]  ctrl_q;
  logic [31:0] div_q;
  logic        sync_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [3:0]  word;
  logic        delay_on;
  logic        lvds_cmos_clock_output_off;
  logic [RATIO_W-1:0] ratio0;
  logic [RATIO_W-1:0] ratio1;
  logic [3:0]  tab_ph0;
  logic [3:0]  tab_ph1;
  logic [3:0]  ph0;
  logic [3:0]  ph1;
  logic        sh0;
  logic        sh1;
  logic        pd0;
  logic        pd1;
  logic        d0_out;
  logic        d1_out;
  logic        d0_run;
  logic        d1_run;
  logic [3:0]  ph0_q;
  logic [3:0]  ph1_q;
  logic [31:0] status;
  logic [13:0] fs_ps;

  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign word   = dpos_word(phase_word_high_pin, phase_word_low_pin);
  assign ratio0 = RATIO_W'(div_q[DPOS_DIV0_RATIO_LSB +: 5]) + 1'b1;
  assign ratio1 = RATIO_W'(div_q[DPOS_DIV1_RATIO_LSB +: 5]) + 1'b1;
  assign tab_ph0 = div_q[DPOS_DIV0_PHASE_LSB +: 4];
  assign tab_ph1 = div_q[DPOS_DIV1_PHASE_LSB +: 4];
  assign delay_on = delay_fullscale_pin != DPOS_LVL_0;

  // Lvds_cmos_clock_output off code on its three divider pins
  assign lvds_cmos_clock_output_off = second_div_sel_a == DPOS_LVL_0 && second_div_sel_b == DPOS_LVL_1
                    && second_div_sel_c == DPOS_LVL_0;

  // Target routing; lvds_cmos_clock_output takes delay instead of phase while delay is on
  always_comb begin
    ph0 = '0;
    ph1 = '0;
    sh0 = 1'b0;
    sh1 = 1'b0;
    unique case (phase_target_select_pin)
      DPOS_LVL_0:   ph1 = delay_on ? 4'h0 : word;
      DPOS_LVL_1_3: ph0 = word;
      DPOS_LVL_2_3: begin
        ph1 = delay_on ? 4'h0 : word;
        sh1 = 1'b1;
      end
      DPOS_LVL_1: begin
        ph0 = word;
        sh0 = 1'b1;
      end
    endcase
    // Divider-table phase wins when nonzero
    if (tab_ph0 != 4'h0) begin
      ph0 = tab_ph0;
    end
    if (tab_ph1 != 4'h0) begin
      ph1 = tab_ph1;
    end
  end

  // Full-scale choice, zero when the delay block is bypassed
  always_comb begin
    unique case (delay_fullscale_pin)
      DPOS_LVL_1_3: fs_ps = 14'(DPOS_FS_A_PS);
      DPOS_LVL_2_3: fs_ps = 14'(DPOS_FS_B_PS);
      DPOS_LVL_1:   fs_ps = 14'(DPOS_FS_C_PS);
      default:      fs_ps = 14'h0;
    endcase
  end

  assign pd0 = ctrl_q[DPOS_CTRL_OFF0_BIT];
  assign pd1 = lvds_cmos_clock_output_off;

  // Write channel capture; address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // Register update and write response; unmapped writes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= DPOS_CTRL_RST;
      div_q        <= DPOS_DIV_RST;
      sync_q       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DPOS_RESP_OKAY;
    end else begin
      sync_q <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= DPOS_RESP_OKAY;
        if (awaddr_q[7:2] == DPOS_CTRL_OFS[7:2]) begin
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[2:0] & 3'h6;
            sync_q <= wdata_q[DPOS_CTRL_SYNC_BIT];
          end
        end else if (awaddr_q[7:2] == DPOS_DIV_OFS[7:2]) begin
          div_q <= dpos_merge(div_q, wdata_q, wstrb_q) & 32'h0f0f_1f1f;
        end else if (awaddr_q[7:2] != DPOS_STATUS_OFS[7:2]
                     && awaddr_q[7:2] != DPOS_DELAY_OFS[7:2]) begin
          s_axi_bresp <= DPOS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings seen by the outputs change only at sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph0_q               <= '0;
      ph1_q               <= '0;
      delay_fine_word     <= '0;
      delay_fullscale_sel <= DPOS_LVL_0;
      delay_amount_ps     <= '0;
      delay_powerdown     <= 1'b1;
      div0_powerdown      <= 1'b1;
      div1_powerdown      <= 1'b1;
      pecl_clock_output_powerdown      <= 1'b0;
      lvds_cmos_clock_output_powerdown      <= 1'b0;
    end else if (sync_q) begin
      ph0_q               <= ph0;
      ph1_q               <= ph1;
      delay_fullscale_sel <= delay_fullscale_pin;
      delay_powerdown     <= !delay_on;
      delay_fine_word     <= (delay_on && !phase_target_select_pin[0]) ? word : 4'h0;
      delay_amount_ps     <= (delay_on && !phase_target_select_pin[0])
                             ? 14'((32'(fs_ps) * word) / DPOS_FINE_STEPS) : 14'h0;
      div0_powerdown      <= pd0 || ratio0 == RATIO_W'(1);
      div1_powerdown      <= pd1 || ratio1 == RATIO_W'(1);
      pecl_clock_output_powerdown      <= pd0;
      lvds_cmos_clock_output_powerdown      <= pd1;
    end
  end

  dpos_divider #(.RATIO_W(RATIO_W), .PHASE_W(4)) u_div0 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ratio      (ratio0),
    .phase      (ph0),
    .start_high (sh0),
    .sync       (sync_q),
    .powerdown  (pd0),
    .div_out_q  (d0_out),
    .running_q  (d0_run)
  );

  dpos_divider #(.RATIO_W(RATIO_W), .PHASE_W(4)) u_div1 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ratio      (ratio1),
    .phase      (ph1),
    .start_high (sh1),
    .sync       (sync_q),
    .powerdown  (pd1),
    .div_out_q  (d1_out),
    .running_q  (d1_run)
  );

  // Output stage registered so pins never glitch on divider logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pecl_clock_output          <= 1'b0;
      lvds_cmos_clock_output     <= 1'b0;
      complementary_clock_output <= 1'b1;
    end else begin
      pecl_clock_output          <= d0_out;
      lvds_cmos_clock_output     <= d1_out;
      complementary_clock_output <= ~d1_out;
    end
  end

  assign status = {8'h0, ph1_q, ph0_q, 3'h0, d1_run, d0_run, lvds_cmos_clock_output_powerdown, pecl_clock_output_powerdown,
                   div1_powerdown, div0_powerdown, delay_powerdown, phase_target_select_pin,
                   word};

  // Read channel, one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= DPOS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= DPOS_RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        DPOS_CTRL_OFS[7:2]:   s_axi_rdata <= {29'h0, ctrl_q};
        DPOS_DIV_OFS[7:2]:    s_axi_rdata <= div_q;
        DPOS_STATUS_OFS[7:2]: s_axi_rdata <= status;
        DPOS_DELAY_OFS[7:2]:  s_axi_rdata <= {18'h0, delay_amount_ps};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= DPOS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  sequence s_sync;
    sync_q;
  endsequence

  delay_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 delay_fullscale_pin == DPOS_LVL_0 |=> delay_powerdown && delay_amount_ps == 14'h0)
    else $error("delay block not bypassed at full-scale level 0");

  fine_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 delay_fullscale_pin == DPOS_LVL_1 && phase_target_select_pin == DPOS_LVL_0
      |=> delay_fine_word == $past(word)
          && delay_amount_ps == 14'($past(word)) * 14'(DPOS_FS_C_PS / DPOS_FINE_STEPS))
    else $error("fine delay not N/16 of full scale");

  lvds_cmos_clock_output_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 lvds_cmos_clock_output_off |=> lvds_cmos_clock_output_powerdown && div1_powerdown)
    else $error("lvds_cmos_clock_output off code did not power down lvds_cmos_clock_output");

  div_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 div_q[DPOS_DIV0_RATIO_LSB +: 5] == 5'h0 |=> div0_powerdown)
    else $error("divide by one not powered down");

  compl_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    complementary_clock_output == ~lvds_cmos_clock_output)
    else $error("complementary output not inverted");

  phase_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 tab_ph0 != 4'h0 |=> ph0_q == $past(tab_ph0))
    else $error("table phase did not override pin word");

  target_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync ##0 tab_ph0 == 4'h0 && phase_target_select_pin == DPOS_LVL_1_3
      |=> ph0_q == $past(word) && ph1_q == $past(tab_ph1))
    else $error("phase word not routed to pecl_clock_output");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

endmodule : dpos_top
`default_nettype wire

// File: tb/dpos_rx_model.sv
// Downstream clock receiver model timing the first rising edges after an arm pulse
`timescale 1ns/100ps
`default_nettype none
module dpos_rx_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic arm,
  input  wire logic clk0,
  input  wire logic clk1,
  input  wire logic clk1_n,
  output var  int   first0,
  output var  int   first1,
  output var  int   bad_pairs
);
  int   cyc;
  logic prev0;
  logic prev1;

  // First edge of each output, in input clock cycles since the arm pulse
  always_ff @(posedge aclk) begin
    prev0 <= clk0;
    prev1 <= clk1;
    cyc   <= arm ? 0 : cyc + 1;
    if (arm) begin
      first0 <= -1;
      first1 <= -1;
    end else begin
      if (clk0 && !prev0 && first0 < 0) first0 <= cyc;
      if (clk1 && !prev1 && first1 < 0) first1 <= cyc;
    end
  end

  // Single-ended receiver pair needs the legs opposite at every edge
  always_ff @(posedge aclk) begin
    if (!aresetn) bad_pairs <= 0;
    else if (clk1_n !== ~clk1) bad_pairs <= bad_pairs + 1;
  end
endmodule : dpos_rx_model
`default_nettype wire

// File: tb/dpos_testbench.sv
// Self-checking bench for the divider phase offset select block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dpos_pkg::*;
  logic        aclk, aresetn, arm, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, delay_fine_word;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, delay_fullscale_sel;
  logic [1:0]  phase_target_select_pin, phase_word_low_pin, phase_word_high_pin;
  logic [1:0]  delay_fullscale_pin, second_div_sel_a, second_div_sel_b, second_div_sel_c;
  logic        pecl_clock_output, lvds_cmos_clock_output, complementary_clock_output;
  logic [13:0] delay_amount_ps;
  logic        delay_powerdown, div0_powerdown, div1_powerdown, pecl_clock_output_powerdown, lvds_cmos_clock_output_powerdown;
  int          first0, first1, bad_pairs, num_errors, n_tests;

  dpos_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .phase_target_select_pin, .phase_word_low_pin, .phase_word_high_pin,
    .delay_fullscale_pin, .second_div_sel_a, .second_div_sel_b, .second_div_sel_c,
    .pecl_clock_output, .lvds_cmos_clock_output, .complementary_clock_output, .delay_fine_word,
    .delay_fullscale_sel, .delay_amount_ps, .delay_powerdown, .div0_powerdown, .div1_powerdown,
    .pecl_clock_output_powerdown, .lvds_cmos_clock_output_powerdown);

  dpos_rx_model rx (.aclk, .aresetn, .arm, .clk0(pecl_clock_output),
    .clk1(lvds_cmos_clock_output), .clk1_n(complementary_clock_output), .first0, .first1,
    .bad_pairs);

  // Free-running 100 MHz input clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A bus wait that ran out ends the run
  task automatic limit(int n);
    if (n >= 100) begin
      num_errors++;
      $display("FAIL bus answer expected within 100 cycles seen none");
      give_verdict();
    end
  endtask : limit

  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // Each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    limit(n);
  endtask : wr

  task automatic rd_reg(logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(n);
  endtask : rd_reg

  // Sync via control write; arm the receiver as the response lands
  task automatic sync(logic [31:0] ctrl);
    wr(DPOS_CTRL_OFS, ctrl | 32'h1);
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : sync

  task automatic set_word(int w);
    @(posedge aclk);
    phase_word_low_pin  <= 2'(w % 4);
    phase_word_high_pin <= 2'(w / 4);
  endtask : set_word

  // Every target level with word 3 and the delay path off
  task automatic t_target();
    set_word(3);
    for (int t = 0; t < 4; t++) begin
      @(posedge aclk);
      phase_target_select_pin <= 2'(t);
      sync(0);
      // Only the output with the offset still shows its start level here
      if (t[0]) check("pecl_clock_output start", pecl_clock_output, t == 3);
      else check("lvds_cmos_clock_output start", lvds_cmos_clock_output, t == 2);
      repeat (40) @(posedge aclk);
      rd_reg(DPOS_STATUS_OFS);
      check("phase0", rd[19:16], t[0] ? 3 : 0);
      check("phase1", rd[23:20], t[0] ? 0 : 3);
      if (t < 2) check("edge lag", t ? first0 - first1 : first1 - first0, 3);
    end
    $display("test target done");
  endtask : t_target

  // Wrap at the ratio, maximum word, then table override
  task automatic t_wrap();
    int w [3] = '{4, 15, 3};
    @(posedge aclk);
    phase_target_select_pin <= DPOS_LVL_1_3;
    for (int i = 0; i < 3; i++) begin
      set_word(w[i]);
      if (i == 2) wr(DPOS_DIV_OFS, 32'h0002_0303);
      sync(0);
      repeat (40) @(posedge aclk);
      check("lag", first0 - first1, i == 2 ? 2 : w[i]);
      rd_reg(DPOS_STATUS_OFS);
      check("phase0 word", rd[19:16], i == 2 ? 2 : w[i]);
    end
    wr(DPOS_DIV_OFS, DPOS_DIV_RST);
    $display("test wrap done");
  endtask : t_wrap

  // Word 8 (low digit 0) as a fine delay over all full scales
  task automatic t_delay();
    int unsigned fs [4] = '{0, DPOS_FS_A_PS, DPOS_FS_B_PS, DPOS_FS_C_PS};
    set_word(8);
    @(posedge aclk);
    phase_target_select_pin <= DPOS_LVL_0;
    // Full scales all under half the 40 ns output period
    for (int f = 0; f < 4; f++) begin
      @(posedge aclk);
      delay_fullscale_pin <= 2'(f);
      sync(32'h2);
      check("delay off", delay_powerdown, f == 0);
      rd_reg(DPOS_STATUS_OFS);
      check("word", rd[3:0], 8);
      if (f > 0) begin
        check("fine", delay_fine_word, 8);
        check("scale", delay_fullscale_sel, f);
        check("ps", delay_amount_ps, fs[f] * 8 / DPOS_FINE_STEPS);
      end
    end
    rd_reg(8'h10);
    check("unmapped", rs, DPOS_RESP_SLVERR);
    $display("test delay done");
  endtask : t_delay

  // Power-down side effects, pins taking effect only at sync
  task automatic t_power();
    check("div1 on", div1_powerdown, 0);
    @(posedge aclk);
    second_div_sel_a <= DPOS_LVL_0;
    second_div_sel_b <= DPOS_LVL_1;
    repeat (3) @(posedge aclk);
    check("lvds_cmos_clock_output before sync", lvds_cmos_clock_output_powerdown, 0);
    sync(0);
    check("lvds_cmos_clock_output off", lvds_cmos_clock_output_powerdown, 1);
    check("div1 off", div1_powerdown, 1);
    sync(32'h4);
    check("pecl_clock_output off", pecl_clock_output_powerdown, 1);
    check("div0 off", div0_powerdown, 1);
    wr(DPOS_DIV_OFS, 32'h0000_0300);
    sync(0);
    check("div0 bypass", div0_powerdown, 1);
    check("pecl_clock_output kept", pecl_clock_output_powerdown, 0);
    $display("test power done");
  endtask : t_power

  initial begin
    num_errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    arm = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {phase_target_select_pin, phase_word_low_pin, phase_word_high_pin} = 6'h00;
    delay_fullscale_pin = DPOS_LVL_0;
    second_div_sel_a = DPOS_LVL_1;
    second_div_sel_b = DPOS_LVL_0;
    second_div_sel_c = DPOS_LVL_0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_target();
    t_wrap();
    t_delay();
    t_power();
    check("pair legs", bad_pairs, 0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
